// ==== design/kld_keypad_ctrl.sv ====
// Keypad LED sink controller: register file, drive source selection and
// registered sink outputs.
// Assumes a register access port from the host and synchronous inputs.
//
// Overview of operation
// - Mode bit high selects switch, low current
// - Sink mode resets to switch mode
// - Each output needs its own on bit
// - Balance 6:4, brightness 3:1, overlap bit 0
// - Brightness code sets logarithmic duty ratio
// - Balance code splits slots, non-overlapping only
// - Overlap mode switches all outputs together
// - Slots share 50 us frame, scaled by brightness
// - Direct mode follows on bits, ignores brightness
// - Scale register holds two bits per output
// - Scale code gives quarter steps of maximum
// - Per-output select picks external PWM followers
// - External PWM input is active high
// - Without internal PWM, selected outputs follow pin
// - With internal PWM, pin gates it by AND
// - Internal PWM runs at 20 kHz
`timescale 1ns/1ns
`include "kld_keypad_cfg.svh"

module kld_keypad_ctrl
   import kld_keypad_pkg::*;
#(
   parameter int FRAME_CYCLES = `KLD_FRAME_CYCLES,
   parameter int CNT_W        = 16
)
(
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire kld_byte_t        regAddr,
   input  wire kld_byte_t        regWrData,
   input  wire logic             regWrEn,
   input  wire logic             regRdEn,
   output kld_byte_t             regRdData,
   input  wire logic             pwmPinEnable,
   input  wire logic             sinkAExternalDutySelect,
   input  wire logic             sinkBExternalDutySelect,
   input  wire logic             sinkCExternalDutySelect,
   input  wire logic             extPwm,
   output logic                  sinkAOutput,
   output logic                  sinkBOutput,
   output logic                  sinkCOutput,
   output logic                  sinkModeSelect,
   output logic      [2:0]       sinkALimit,
   output logic      [2:0]       sinkBLimit,
   output logic      [2:0]       sinkCLimit
);

   kld_byte_t        ctrl_r;
   kld_byte_t        ctrl_nxt;
   kld_byte_t        brightBal_r;
   kld_byte_t        brightBal_nxt;
   kld_byte_t        curScale_r;
   kld_byte_t        curScale_nxt;
   kld_byte_t        rdData_r;
   kld_byte_t        rdData_nxt;
   logic      [2:0]  out_r;
   logic      [2:0]  out_nxt;
   logic      [8:0]  limit_r;
   logic      [8:0]  limit_nxt;
   logic      [2:0]  onBit;
   logic      [2:0]  extSel;
   logic      [2:0]  intDuty;
   kld_scale_t       scale     [3];
   logic             blockEn;
   logic             intSel;

   // ----------------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------------
   // Writes land next edge; reserved bits are kept at zero
   always_comb
   begin
      ctrl_nxt      = ctrl_r;
      brightBal_nxt = brightBal_r;
      curScale_nxt  = curScale_r;
      if (regWrEn)
      begin
         case (regAddr)
            `KLD_OFS_CONTROL:    ctrl_nxt      = regWrData & `KLD_CTL_MASK;
            `KLD_OFS_BRIGHT_BAL: brightBal_nxt = regWrData & `KLD_BB_MASK;
            `KLD_OFS_CUR_SCALE:  curScale_nxt  = regWrData & `KLD_CS_MASK;
            default:             ctrl_nxt      = ctrl_r;
         endcase
      end
   end

   // Read data is held until the next read; unmapped offsets read zero
   always_comb
   begin
      rdData_nxt = rdData_r;
      if (regRdEn)
      begin
         case (regAddr)
            `KLD_OFS_CONTROL:    rdData_nxt = ctrl_r;
            `KLD_OFS_BRIGHT_BAL: rdData_nxt = brightBal_r;
            `KLD_OFS_CUR_SCALE:  rdData_nxt = curScale_r;
            default:             rdData_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         ctrl_r      <= `KLD_CTL_RESET;
         brightBal_r <= `KLD_BB_RESET;
         curScale_r  <= `KLD_CS_RESET;
         rdData_r    <= 8'h00;
      end
      else
      begin
         ctrl_r      <= ctrl_nxt;
         brightBal_r <= brightBal_nxt;
         curScale_r  <= curScale_nxt;
         rdData_r    <= rdData_nxt;
      end
   end

   assign regRdData      = rdData_r;
   assign sinkModeSelect = ctrl_r[`KLD_CTL_SINK_MODE];

   // ----------------------------------------------------------------------
   // Internal PWM
   // ----------------------------------------------------------------------
   // Host must set enable and internal select for this path to be used
   kld_slot_gen #(
      .FRAME_CYCLES (FRAME_CYCLES),
      .CNT_W        (CNT_W)
   ) u_slot_gen (
      .clock        (clock),
      .rst_n        (rst_n),
      .brightCode   (brightBal_r[`KLD_BB_BRI_HI:`KLD_BB_BRI_LO]),
      .balanceCode  (brightBal_r[`KLD_BB_BAL_HI:`KLD_BB_BAL_LO]),
      .overlapSel   (brightBal_r[`KLD_BB_OVERLAP]),
      .intDuty      (intDuty)
   );

   // ----------------------------------------------------------------------
   // Output drive
   // ----------------------------------------------------------------------
   assign blockEn  = ctrl_r[`KLD_CTL_BLOCK_EN];
   assign intSel   = ctrl_r[`KLD_CTL_INT_DUTY];
   assign onBit    = {ctrl_r[`KLD_CTL_SINK_C_ON], ctrl_r[`KLD_CTL_SINK_B_ON],
                      ctrl_r[`KLD_CTL_SINK_A_ON]};
   // Pin select only counts when the pin is given over to PWM
   assign extSel   = {sinkCExternalDutySelect, sinkBExternalDutySelect,
                      sinkAExternalDutySelect} & {3{pwmPinEnable}};
   assign scale[0] = curScale_r[`KLD_CS_SINK_A_LO +: 2];
   assign scale[1] = curScale_r[`KLD_CS_SINK_B_LO +: 2];
   assign scale[2] = curScale_r[`KLD_CS_SINK_C_LO +: 2];

   // Per-output source choice and current limit in quarters of maximum
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_sink
         assign out_nxt[gi] = blockEn & onBit[gi] &
            (extSel[gi] ? (intSel ? (intDuty[gi] & extPwm)
                                  : extPwm)
                        : (intSel ? intDuty[gi] : 1'b1));
         assign limit_nxt[gi*3 +: 3] = {1'b0, scale[gi]} + 3'h1;
      end
   endgenerate

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         out_r   <= 3'h0;
         limit_r <= `KLD_LIMIT_RESET;
      end
      else
      begin
         out_r   <= out_nxt;
         limit_r <= limit_nxt;
      end
   end

   assign sinkAOutput = out_r[0];
   assign sinkBOutput = out_r[1];
   assign sinkCOutput = out_r[2];
   assign sinkALimit  = limit_r[2:0];
   assign sinkBLimit  = limit_r[5:3];
   assign sinkCLimit  = limit_r[8:6];

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   a_block_off: assert property (@(posedge clock) disable iff (!rst_n)
      !blockEn |=> out_r == 3'h0)
      else $error("outputs on while keypad disabled");
   a_on_bit: assert property (@(posedge clock) disable iff (!rst_n)
      !onBit[0] |=> !sinkAOutput)
      else $error("output on without its on bit");
   a_direct_drive: assert property (@(posedge clock) disable iff (!rst_n)
      blockEn && !intSel && !extSel[1] && onBit[1] |=> sinkBOutput)
      else $error("direct mode output not held on");
   a_ext_follow: assert property (@(posedge clock) disable iff (!rst_n)
      blockEn && !intSel && extSel[2] && onBit[2]
      |=> sinkCOutput == $past(extPwm))
      else $error("selected output does not follow pin");
   a_ext_gate: assert property (@(posedge clock) disable iff (!rst_n)
      intSel && extSel[0] && !extPwm |=> !sinkAOutput)
      else $error("internal duty passed while pin low");
   a_ext_ignore: assert property (@(posedge clock) disable iff (!rst_n)
      blockEn && intSel && !extSel[0] && onBit[0]
      |=> sinkAOutput == $past(intDuty[0]))
      else $error("unselected output reacted to pin");
   a_mode_reset: assert property (@(posedge clock)
      !rst_n |=> sinkModeSelect)
      else $error("sink mode not switch after reset");
   a_mode_write: assert property (@(posedge clock) disable iff (!rst_n)
      regWrEn && regAddr == `KLD_OFS_CONTROL
      |=> sinkModeSelect == $past(regWrData[`KLD_CTL_SINK_MODE]))
      else $error("sink mode bit not taken");
   a_scale_map: assert property (@(posedge clock) disable iff (!rst_n)
      regWrEn && regAddr == `KLD_OFS_CUR_SCALE
      |=> ##1 sinkALimit == {1'b0, $past(regWrData[5:4], 2)} + 3'h1)
      else $error("current limit does not match scale");
   a_bal_read: assert property (@(posedge clock) disable iff (!rst_n)
      regWrEn && regAddr == `KLD_OFS_BRIGHT_BAL ##1 !regWrEn ##1 regRdEn && !regWrEn
      && regAddr == `KLD_OFS_BRIGHT_BAL
      |=> regRdData == ($past(regWrData, 3) & `KLD_BB_MASK))
      else $error("brightness register read back wrong");

   c_direct:  cover property (@(posedge clock) disable iff (!rst_n)
      blockEn && !intSel && sinkAOutput);
   c_int_pwm: cover property (@(posedge clock) disable iff (!rst_n)
      intSel && $rose(sinkBOutput));
   c_ext_pin: cover property (@(posedge clock) disable iff (!rst_n)
      extSel[2] && $fell(sinkCOutput));
   c_cc_mode: cover property (@(posedge clock) disable iff (!rst_n)
      !sinkModeSelect && sinkCLimit == 3'h4);

endmodule

// ==== design/kld_keypad_cfg.svh ====
// Keypad LED controller constants: register offsets, field positions,
// reset values and PWM timing figures.
// Assumes a 100 MHz core clock; included by bare name.
`ifndef KLD_KEYPAD_CFG_SVH
`define KLD_KEYPAD_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define KLD_OFS_CONTROL       8'h00
`define KLD_OFS_BRIGHT_BAL    8'h01
`define KLD_OFS_CUR_SCALE     8'h02

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define KLD_CTL_SINK_A_ON     0
`define KLD_CTL_SINK_B_ON     1
`define KLD_CTL_SINK_C_ON     2
`define KLD_CTL_INT_DUTY      3
`define KLD_CTL_BLOCK_EN      4
`define KLD_CTL_SINK_MODE     5
`define KLD_CTL_RESET         8'h20
`define KLD_CTL_MASK          8'h3F

// ----------------------------------------------------------------------
// Brightness and balance register fields
// ----------------------------------------------------------------------
`define KLD_BB_BAL_HI         6
`define KLD_BB_BAL_LO         4
`define KLD_BB_BRI_HI         3
`define KLD_BB_BRI_LO         1
`define KLD_BB_OVERLAP        0
`define KLD_BB_RESET          8'h00
`define KLD_BB_MASK           8'h7F

// ----------------------------------------------------------------------
// Current scale register fields
// ----------------------------------------------------------------------
`define KLD_CS_SINK_A_LO      4
`define KLD_CS_SINK_B_LO      2
`define KLD_CS_SINK_C_LO      0
`define KLD_CS_RESET          8'h00
`define KLD_CS_MASK           8'h3F
`define KLD_LIMIT_RESET       9'h049

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define KLD_CLK_MHZ           100
`define KLD_FRAME_US          50
`define KLD_FRAME_CYCLES      (`KLD_FRAME_US * `KLD_CLK_MHZ)

`endif

// ==== design/kld_keypad_pkg.sv ====
// Keypad LED controller types.
// Assumes kld_keypad_cfg.svh holds the numeric constants.
package kld_keypad_pkg;

   typedef logic [2:0] kld_code_t;
   typedef logic [1:0] kld_scale_t;
   typedef logic [7:0] kld_byte_t;

endpackage

// ==== design/kld_slot_gen.sv ====
// Internal keypad PWM: frame counter plus brightness and balance decode.
// Assumes a free running clock; codes come from the register file.
`timescale 1ns/1ns
`include "kld_keypad_cfg.svh"

module kld_slot_gen
   import kld_keypad_pkg::*;
#(
   parameter int FRAME_CYCLES = `KLD_FRAME_CYCLES,
   parameter int CNT_W        = 16
)
(
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire kld_code_t        brightCode,
   input  wire kld_code_t        balanceCode,
   input  wire logic             overlapSel,
   output logic      [2:0]       intDuty
);

   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic [2:0]       duty_r;
   logic [2:0]       duty_nxt;
   logic [CNT_W-1:0] len;
   logic             win;
   logic [CNT_W+1:0] p1;
   logic [CNT_W+1:0] p2;
   logic [CNT_W+1:0] p3;
   logic [CNT_W+1:0] p4;
   logic [CNT_W+1:0] l1;
   logic [CNT_W+1:0] l2;
   logic [CNT_W+1:0] l3;

   // ----------------------------------------------------------------------
   // Frame counter
   // ----------------------------------------------------------------------
   // One frame per PWM period, 20 kHz at the nominal clock
   always_comb
   begin
      if (cnt_r == CNT_W'(FRAME_CYCLES - 1))
         cnt_nxt = '0;
      else
         cnt_nxt = cnt_r + 1'b1;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         cnt_r <= '0;
      else
         cnt_r <= cnt_nxt;
   end

   // ----------------------------------------------------------------------
   // Duty decode
   // ----------------------------------------------------------------------
   // Active length halves for each step down from full brightness to code 1; code 0 gives none
   always_comb
   begin
      if (brightCode == 3'h0)
         len = '0;
      else
         len = CNT_W'(FRAME_CYCLES) >> (3'h7 - brightCode);
   end

   // Slot boundaries scale with the active length, so dim frames end with a dark tail
   assign win = (cnt_r < len);
   assign p1  = {2'b00, cnt_r};
   assign p2  = p1 << 1;
   assign p3  = p1 + p2;
   assign p4  = p1 << 2;
   assign l1  = {2'b00, len};
   assign l2  = l1 << 1;
   assign l3  = l1 + l2;

   // Overlap drives all together; otherwise each slot belongs to one output
   always_comb
   begin
      duty_nxt = 3'h0;
      if (overlapSel)
         duty_nxt = {3{win}};
      else
      begin
         case (balanceCode)
            3'h0: duty_nxt = {2'b00, win};
            3'h1: duty_nxt = {1'b0, win, 1'b0};
            3'h2: duty_nxt = {win, 2'b00};
            3'h3: duty_nxt = {1'b0, win & !(p2 < l1), win & (p2 < l1)};
            3'h4: duty_nxt = {win & !(p2 < l1), win & (p2 < l1), 1'b0};
            3'h5: duty_nxt = {win & !(p2 < l1), 1'b0, win & (p2 < l1)};
            3'h6: duty_nxt = {win & !(p3 < l2), win & !(p3 < l1) & (p3 < l2),
                              win & (p3 < l1)};
            3'h7: duty_nxt = {win & !(p4 < l3), win & !(p2 < l1) & (p4 < l3),
                              win & (p2 < l1)};
            default: duty_nxt = 3'h0;
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         duty_r <= 3'h0;
      else
         duty_r <= duty_nxt;
   end

   assign intDuty = duty_r;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   a_frame_wrap: assert property (@(posedge clock) disable iff (!rst_n)
      cnt_r == CNT_W'(FRAME_CYCLES - 1) |=> cnt_r == '0)
      else $error("frame counter did not wrap");
   a_zero_bright: assert property (@(posedge clock) disable iff (!rst_n)
      brightCode == 3'h0 |=> duty_r == 3'h0)
      else $error("zero brightness still drives");
   a_overlap_full: assert property (@(posedge clock) disable iff (!rst_n)
      overlapSel && brightCode == 3'h7 |=> duty_r == 3'h7)
      else $error("overlap full brightness not all on");
   a_slot_excl: assert property (@(posedge clock) disable iff (!rst_n)
      !overlapSel |=> $onehot0(duty_r))
      else $error("slots overlap in non-overlapping mode");
   a_half_tail: assert property (@(posedge clock) disable iff (!rst_n)
      !overlapSel && brightCode == 3'h6 && 32'(cnt_r) >= FRAME_CYCLES / 2
      |=> duty_r == 3'h0)
      else $error("half brightness tail not dark");

endmodule

// ==== verification/kld_led_strings.sv ====
// Three keypad LED strings: counts the cycles each string conducts.
// Assumes sink outputs are registered on the rising clock edge.
`timescale 1ns/1ns

module kld_led_strings
(
   input  wire logic clock,
   input  wire logic clear,
   input  wire logic sinkA,
   input  wire logic sinkB,
   input  wire logic sinkC,
   output int        litA,
   output int        litB,
   output int        litC
);
   // ------------------------------------------------------------
   // Lit-cycle counters
   // ------------------------------------------------------------
   // A string lights only while its sink is firmly on
   always_ff @(posedge clock)
   begin
      litA <= clear ? 0 : litA + int'(sinkA === 1'b1);
      litB <= clear ? 0 : litB + int'(sinkB === 1'b1);
      litC <= clear ? 0 : litC + int'(sinkC === 1'b1);
   end
endmodule

// ==== verification/keypad_led_pwm_controller_bench.sv ====
// Self-checking bench for the keypad LED sink controller.
// Assumes a 64-cycle frame so duty ratios stay exact.
`timescale 1ns/1ns
`include "kld_keypad_cfg.svh"

module keypad_led_pwm_controller_bench
   import kld_keypad_pkg::*;
;
   logic      clock = 1'b0;
   logic      rst_n = 1'b0;
   kld_byte_t regAddr = 8'h00;
   kld_byte_t regWrData = 8'h00;
   logic      regWrEn = 1'b0;
   logic      regRdEn = 1'b0;
   kld_byte_t regRdData;
   logic      pwmPinEnable = 1'b0;
   logic      selA = 1'b0;
   logic      selB = 1'b0;
   logic      selC = 1'b0;
   logic      extPwm = 1'b0;
   logic      outA, outB, outC, sinkModeSelect, clear = 1'b0;
   logic [2:0] limA, limB, limC;
   int        litA, litB, litC;
   int        n_errors = 0;
   int        checks = 0;
   int        balA[8] = '{64, 0, 0, 32, 0, 32, 22, 32};
   int        balB[8] = '{0, 64, 0, 32, 32, 0, 21, 16};
   int        balC[8] = '{0, 0, 64, 0, 32, 32, 21, 16};

   // ------------------------------------------------------------
   // Clock, design and LED strings
   // ------------------------------------------------------------
   always #5 clock = ~clock;

   kld_keypad_ctrl #(.FRAME_CYCLES(64)) DUT
   (
      .clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
      .pwmPinEnable(pwmPinEnable), .sinkAExternalDutySelect(selA),
      .sinkBExternalDutySelect(selB), .sinkCExternalDutySelect(selC),
      .extPwm(extPwm), .sinkAOutput(outA), .sinkBOutput(outB), .sinkCOutput(outC),
      .sinkModeSelect(sinkModeSelect), .sinkALimit(limA), .sinkBLimit(limB),
      .sinkCLimit(limC)
   );

   kld_led_strings strings
   (
      .clock(clock), .clear(clear), .sinkA(outA), .sinkB(outB), .sinkC(outC),
      .litA(litA), .litB(litB), .litC(litC)
   );

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic close_out;
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic wr(input kld_byte_t a, input kld_byte_t d);
      @(negedge clock);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(negedge clock);
      regWrEn = 1'b0;
   endtask

   task automatic rd(input kld_byte_t a, input kld_byte_t exp);
      @(negedge clock);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge clock);
      regRdEn = 1'b0;
      check(regRdData, exp);
   endtask

   // Let a write reach the sink outputs, then compare A, B, C
   task automatic outs(input logic [2:0] exp);
      repeat (4) @(negedge clock);
      check({5'h00, outA, outB, outC}, {5'h00, exp});
   endtask

   // Count lit cycles over two whole frames
   task automatic lit(input int a, input int b, input int c);
      repeat (4) @(negedge clock);
      clear = 1'b1;
      @(negedge clock);
      clear = 1'b0;
      repeat (128) @(negedge clock);
      check(8'(litA), 8'(a));
      check(8'(litB), 8'(b));
      check(8'(litC), 8'(c));
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      rd(`KLD_OFS_CONTROL, 8'h20);
      rd(`KLD_OFS_BRIGHT_BAL, 8'h00);
      rd(`KLD_OFS_CUR_SCALE, 8'h00);
      check({7'h00, sinkModeSelect}, 8'h01);
      check({5'h00, limA}, 8'h01);
      check({5'h00, limB}, 8'h01);
      check({5'h00, limC}, 8'h01);
      outs(3'b000);
      $display("done: reset values");
   endtask

   task automatic t_regs;
      wr(`KLD_OFS_BRIGHT_BAL, 8'hFF);
      rd(`KLD_OFS_BRIGHT_BAL, 8'h7F);
      wr(`KLD_OFS_CUR_SCALE, 8'hFF);
      rd(`KLD_OFS_CUR_SCALE, 8'h3F);
      wr(8'h03, 8'hAA);
      rd(8'h03, 8'h00);
      rd(`KLD_OFS_CONTROL, 8'h20);
      wr(`KLD_OFS_CUR_SCALE, 8'h1B);
      outs(3'b000);
      check({5'h00, limA}, 8'h02);
      check({5'h00, limB}, 8'h03);
      check({5'h00, limC}, 8'h04);
      wr(`KLD_OFS_CONTROL, 8'h00);
      outs(3'b000);
      check({7'h00, sinkModeSelect}, 8'h00);
      $display("done: register file");
   endtask

   task automatic t_direct;
      wr(`KLD_OFS_BRIGHT_BAL, 8'h00);
      wr(`KLD_OFS_CONTROL, 8'h35);
      outs(3'b101);
      check({7'h00, sinkModeSelect}, 8'h01);
      wr(`KLD_OFS_CONTROL, 8'h0F);
      outs(3'b000);
      $display("done: direct mode");
   endtask

   task automatic t_overlap;
      int len;
      wr(`KLD_OFS_CONTROL, 8'h3F);
      for (int code = 0; code < 8; code++)
      begin
         len = (code == 0) ? 0 : (64 >> (7 - code));
         wr(`KLD_OFS_BRIGHT_BAL, {4'h0, 3'(code), 1'b1});
         lit(2 * len, 2 * len, 2 * len);
      end
      $display("done: overlapping duty");
   endtask

   task automatic t_balance;
      wr(`KLD_OFS_CONTROL, 8'h3F);
      for (int b = 0; b < 8; b++)
      begin
         wr(`KLD_OFS_BRIGHT_BAL, {1'b0, 3'(b), 3'h7, 1'b0});
         lit(2 * balA[b], 2 * balB[b], 2 * balC[b]);
      end
      wr(`KLD_OFS_BRIGHT_BAL, {1'b0, 3'h3, 3'h6, 1'b0});
      lit(32, 32, 0);
      $display("done: balance slots");
   endtask

   task automatic t_external;
      pwmPinEnable = 1'b1;
      selA = 1'b1;
      selC = 1'b1;
      wr(`KLD_OFS_CONTROL, 8'h17);
      outs(3'b010);
      extPwm = 1'b1;
      outs(3'b111);
      wr(`KLD_OFS_BRIGHT_BAL, 8'h0F);
      wr(`KLD_OFS_CONTROL, 8'h1F);
      outs(3'b111);
      extPwm = 1'b0;
      outs(3'b010);
      extPwm = 1'b1;
      wr(`KLD_OFS_BRIGHT_BAL, 8'h01);
      outs(3'b000);
      selB = 1'b1;
      wr(`KLD_OFS_BRIGHT_BAL, 8'h0F);
      outs(3'b111);
      extPwm = 1'b0;
      outs(3'b000);
      selB = 1'b0;
      $display("done: external pwm");
   endtask

   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial
   begin
      repeat (12) @(negedge clock);
      rst_n = 1'b1;
      t_reset();
      t_regs();
      t_direct();
      t_overlap();
      t_balance();
      t_external();
      close_out();
   end

   initial
   begin
      #200000;
      n_errors++;
      close_out();
   end
endmodule
